/* File: src/cps_consts.svh */
// Constants of the codec control-port host controller
// Functional notes
// - Frame is chip address 01, direction bit, 5-bit address, 8-bit data, MSB first.
// - Three-wire port is write only; direction bit always sent as 1.
// - Chip select returns high after every 16-clock frame.
// - Serial control clock never runs faster than 5 MHz.
// - Two-wire mode is a fast-mode slave with bus clock at most 400 kHz.
// - Powerdown pin released high no sooner than 150 ns after power.
// - Power, PLL, DAC, clock-out and master bits written only after powerdown high.
// - Headphone path select bits set only after PLL lock.
// - Headphone power and unmute set at least 2 ms after path select.
// - At power-down clear headphone power first, then path select bits.
// - Lineout path select after PLL lock, then lineout power.
// - Mono path select after PLL lock, then mono output power.
// - Bypass paths: common voltage power after powerdown high, then input select; code checks only powerdown high, not this order.
// - Bypass to lineout: lineout power at least 2 ms after input select.
// - Host never writes register addresses 14H through 1FH.
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// Wishbone register map (byte addresses)
`define CPS_WB_CTRL       8'h00
`define CPS_WB_CMD        8'h04
`define CPS_WB_STAT       8'h08
// Control register fields
`define CPS_CTRL_RELEASE  0
`define CPS_CTRL_TWOWIRE  1
// Command register fields
`define CPS_CMD_DATA_LSB  0
`define CPS_CMD_ADDR_LSB  8
// Status register fields
`define CPS_ST_BUSY       0
`define CPS_ST_REFUSED    1
`define CPS_ST_WAIT_LOCK  2
`define CPS_ST_WAIT_SETL  3
`define CPS_ST_LOCKED     4
`define CPS_ST_PIN_HIGH   5
`define CPS_ST_PUP_DONE   6

// Frame layout
`define CPS_CHIP_ADDR     2'b01
`define CPS_DIR_WRITE     1'b1
`define CPS_FRAME_BITS    16
`define CPS_REG_LIMIT     5'h14

// Device register addresses and bit groups
`define CPS_REG_PWR       5'h00
`define CPS_REG_HP_SEL0   5'h07
`define CPS_REG_LO_SEL0   5'h08
`define CPS_REG_HP_SEL    5'h0d
`define CPS_REG_LO_SEL    5'h0f
`define CPS_REG_MO_SEL    5'h12
`define CPS_REG_MO_ATT    5'h13
`define CPS_DAC_PATH_MASK 8'h03
`define CPS_PWR_OUT_MASK  8'h3c
`define CPS_MO_PWR_MASK   8'h40
`define CPS_HP_PWR_MASK   8'h0c

// Timing
`define CPS_CLK_KHZ       200000
`define CPS_CLK_MHZ       200
`define CPS_SCLK_MAX_KHZ  5000
`define CPS_HALF_CYC      ((`CPS_CLK_KHZ + 2 * `CPS_SCLK_MAX_KHZ - 1) / (2 * `CPS_SCLK_MAX_KHZ))
`define CPS_T_PUP_NS      150
`define CPS_PUP_CYC       ((`CPS_T_PUP_NS * `CPS_CLK_MHZ + 999) / 1000)
`define CPS_T_SETTLE_US   2000
`define CPS_SETTLE_CYC    (`CPS_T_SETTLE_US * `CPS_CLK_MHZ)
`define CPS_TWOWIRE_KHZ   400

`endif

/* File: src/cps_pkg.sv */
// Types shared by the control-port host controller
`default_nettype none
package cps_pkg;
  typedef enum logic [1:0] {
    CPS_IDLE = 2'b00,
    CPS_WAIT = 2'b01,
    CPS_SEND = 2'b10
  } cps_state_e;
endpackage : cps_pkg
`default_nettype wire

/* File: src/cps_timer.sv */
// Retriggerable delay timer, busy for a fixed number of cycles
`include "cps_consts.svh"
`default_nettype none
module cps_timer
  import cps_pkg::*;
#(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic start,
  output var  logic busy
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] CYC_W = W'(CYCLES);
  localparam logic [W-1:0] ONE_W = W'(1);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= CYC_W;
      busy  <= 1'b1;
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - ONE_W;
      busy  <= (cnt_r != ONE_W);
    end
  end
endmodule : cps_timer
`default_nettype wire

/* File: src/cps_serial_tx.sv */
// Three-wire write-frame shifter with its own serial clock divider
`include "cps_consts.svh"
`default_nettype none
module cps_serial_tx
  import cps_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic [4:0] regAddr,
  input  wire logic [7:0] regData,
  output var  logic       busy,
  output var  logic       chipSelectLow,
  output var  logic       controlSerialClock,
  output var  logic       controlSerialIn
);
  localparam logic [4:0] HALF_LAST = 5'(`CPS_HALF_CYC - 1);
  localparam logic [5:0] IDX_CS    = 6'(2 * `CPS_FRAME_BITS);

  logic [4:0]  div_r;
  logic [5:0]  idx_r;
  logic [15:0] shift_r;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy               <= 1'b0;
      chipSelectLow      <= 1'b1;
      controlSerialClock <= 1'b1;
      controlSerialIn    <= 1'b0;
      div_r              <= '0;
      idx_r              <= '0;
      shift_r            <= '0;
    end
    else if (start && !busy)
    begin
      busy          <= 1'b1;
      chipSelectLow <= 1'b0;
      div_r         <= '0;
      idx_r         <= '0;
      shift_r       <= {`CPS_CHIP_ADDR, `CPS_DIR_WRITE, regAddr, regData};
    end
    else if (busy)
    begin
      if (div_r == HALF_LAST)
      begin
        div_r <= '0;
        idx_r <= idx_r + 6'h01;
        if (idx_r < IDX_CS)
        begin
          if (!idx_r[0])
          begin
            controlSerialClock <= 1'b0;
            controlSerialIn    <= shift_r[15];
            shift_r            <= {shift_r[14:0], 1'b0};
          end
          else
            controlSerialClock <= 1'b1;
        end
        else if (idx_r == IDX_CS)
          chipSelectLow <= 1'b1;
        else
          busy <= 1'b0;
      end
      else
        div_r <= div_r + 5'h01;
    end
  end
endmodule : cps_serial_tx
`default_nettype wire

/* File: src/cps_ctrl.sv */
// Host controller for the codec control port: Wishbone registers, frame guard, pins
`include "cps_consts.svh"
`default_nettype none
module cps_ctrl
  import cps_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `CPS_SETTLE_CYC
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        pllLockedIn,
  output var  logic        powerdownPin,
  output var  logic        interfaceSelect,
  output var  logic        chipSelectLow,
  output var  logic        controlSerialClock,
  output var  logic        controlSerialIn
);
  // Path select writes that switch DAC audio onto an output
  function automatic logic needsLock(input logic [4:0] a, input logic [7:0] d);
    needsLock = ((a == `CPS_REG_HP_SEL0) || (a == `CPS_REG_LO_SEL0) || (a == `CPS_REG_MO_SEL))
                && ((d & `CPS_DAC_PATH_MASK) != 8'h00);
  endfunction : needsLock

  // Any path select write that enables a route
  function automatic logic isPathSel(input logic [4:0] a, input logic [7:0] d);
    isPathSel = ((a == `CPS_REG_HP_SEL0) || (a == `CPS_REG_LO_SEL0) || (a == `CPS_REG_HP_SEL)
                 || (a == `CPS_REG_LO_SEL) || (a == `CPS_REG_MO_SEL)) && (d != 8'h00);
  endfunction : isPathSel

  // Output power writes that must wait for the path to settle
  function automatic logic needsSettle(input logic [4:0] a, input logic [7:0] d);
    needsSettle = ((a == `CPS_REG_PWR) && ((d & `CPS_PWR_OUT_MASK) != 8'h00))
                  || ((a == `CPS_REG_MO_ATT) && ((d & `CPS_MO_PWR_MASK) != 8'h00));
  endfunction : needsSettle

  // Write that turns every route of a headphone select register off
  function automatic logic hpPathOff(input logic [4:0] a, input logic [7:0] d);
    hpPathOff = ((a == `CPS_REG_HP_SEL0) || (a == `CPS_REG_HP_SEL)) && (d == 8'h00);
  endfunction : hpPathOff

  cps_state_e  state_r;
  logic        release_r;
  logic        pupStarted_r;
  logic        pupBusy;
  logic        pupDone;
  logic        settleBusy;
  logic        settleStart;
  logic        lockMeta_r;
  logic        lockSync_r;
  logic        refused_r;
  logic        hpPwrOn_r;
  logic [4:0]  cmdAddr_r;
  logic [7:0]  cmdData_r;
  logic        txStart;
  logic        txBusy;
  logic        wbHit;
  logic        cmdWrite;
  logic        cmdOk;
  logic        waitLock;
  logic        waitSettle;
  logic        refuseNow;
  logic        abortWait;
  logic [31:0] rdData;

  assign wbHit    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmdWrite = wbHit && wb_we_i && (wb_adr_i == `CPS_WB_CMD) && (&wb_sel_i[1:0]);
  assign pupDone  = pupStarted_r && !pupBusy;
  assign waitLock   = needsLock(cmdAddr_r, cmdData_r) && !lockSync_r;
  assign waitSettle = needsSettle(cmdAddr_r, cmdData_r) && settleBusy;
  assign txStart    = (state_r == CPS_WAIT) && !waitLock && !waitSettle && powerdownPin;
  assign settleStart = txStart && isPathSel(cmdAddr_r, cmdData_r);
  assign abortWait  = (state_r == CPS_WAIT) && !powerdownPin;

  // Commands are refused when busy, in two-wire mode, in powerdown or out of range
  assign cmdOk = (state_r == CPS_IDLE) && powerdownPin && !interfaceSelect
                 && (wb_dat_i[`CPS_CMD_ADDR_LSB +: 5] < `CPS_REG_LIMIT)
                 && !(hpPwrOn_r && hpPathOff(wb_dat_i[`CPS_CMD_ADDR_LSB +: 5],
                                             wb_dat_i[`CPS_CMD_DATA_LSB +: 8]));
  assign refuseNow = (cmdWrite && !cmdOk) || abortWait;

  // Lock indication from the device side crosses in through two flops
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lockMeta_r <= 1'b0;
      lockSync_r <= 1'b0;
    end
    else
    begin
      lockMeta_r <= pllLockedIn;
      lockSync_r <= lockMeta_r;
    end
  end

  // Headphone power as last sent; its path may not be switched off while it is on.
  // Waiting for the outputs to reach ground stays with software.
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      hpPwrOn_r <= 1'b0;
    else if (!powerdownPin)
      hpPwrOn_r <= 1'b0;
    else if (txStart && (cmdAddr_r == `CPS_REG_PWR))
      hpPwrOn_r <= ((cmdData_r & `CPS_HP_PWR_MASK) != 8'h00);
  end

  // Minimum hold of the powerdown pin after reset
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      pupStarted_r <= 1'b0;
    else
      pupStarted_r <= 1'b1;
  end

  cps_timer #(
    .CYCLES (`CPS_PUP_CYC)
  ) u_pup_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (!pupStarted_r),
    .busy    (pupBusy)
  );

  cps_timer #(
    .CYCLES (SETTLE_CYC)
  ) u_settle_timer (
    .clock   (clock),
    .sys_rst (sys_rst),
    .start   (settleStart),
    .busy    (settleBusy)
  );

  // Control register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      release_r       <= 1'b0;
      interfaceSelect <= 1'b0;
    end
    else if (wbHit && wb_we_i && (wb_adr_i == `CPS_WB_CTRL) && wb_sel_i[0])
    begin
      release_r       <= wb_dat_i[`CPS_CTRL_RELEASE];
      interfaceSelect <= wb_dat_i[`CPS_CTRL_TWOWIRE];
    end
  end

  // Powerdown pin: low after reset, raised only once software asks and the hold ran out
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      powerdownPin <= 1'b0;
    else
      powerdownPin <= release_r && pupDone;
  end

  // Command latch
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cmdAddr_r <= '0;
      cmdData_r <= '0;
    end
    else if (cmdWrite && cmdOk)
    begin
      cmdAddr_r <= wb_dat_i[`CPS_CMD_ADDR_LSB +: 5];
      cmdData_r <= wb_dat_i[`CPS_CMD_DATA_LSB +: 8];
    end
  end

  // Sequencer: hold each write until its ordering condition is met
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= CPS_IDLE;
    else
    begin
      case (state_r)
        CPS_IDLE:
        begin
          if (cmdWrite && cmdOk)
            state_r <= CPS_WAIT;
        end
        CPS_WAIT:
        begin
          if (abortWait)
            state_r <= CPS_IDLE;
          else if (txStart)
            state_r <= CPS_SEND;
        end
        CPS_SEND:
        begin
          if (!txBusy && !txStart)
            state_r <= CPS_IDLE;
        end
        default:
          state_r <= CPS_IDLE;
      endcase
    end
  end

  // Refused flag: sticky; a new refusal wins over a clear in the same cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      refused_r <= 1'b0;
    else if (refuseNow)
      refused_r <= 1'b1;
    else if (wbHit && wb_we_i && (wb_adr_i == `CPS_WB_STAT) && wb_sel_i[0]
             && wb_dat_i[`CPS_ST_REFUSED])
      refused_r <= 1'b0;
  end

  cps_serial_tx u_tx (
    .clock              (clock),
    .sys_rst            (sys_rst),
    .start              (txStart),
    .regAddr            (cmdAddr_r),
    .regData            (cmdData_r),
    .busy               (txBusy),
    .chipSelectLow      (chipSelectLow),
    .controlSerialClock (controlSerialClock),
    .controlSerialIn    (controlSerialIn)
  );

  // Read mux
  always_comb
  begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      `CPS_WB_CTRL:
      begin
        rdData[`CPS_CTRL_RELEASE] = release_r;
        rdData[`CPS_CTRL_TWOWIRE] = interfaceSelect;
      end
      `CPS_WB_CMD:
      begin
        rdData[`CPS_CMD_ADDR_LSB +: 5] = cmdAddr_r;
        rdData[`CPS_CMD_DATA_LSB +: 8] = cmdData_r;
      end
      `CPS_WB_STAT:
      begin
        rdData[`CPS_ST_BUSY]      = (state_r != CPS_IDLE);
        rdData[`CPS_ST_REFUSED]   = refused_r;
        rdData[`CPS_ST_WAIT_LOCK] = (state_r == CPS_WAIT) && waitLock;
        rdData[`CPS_ST_WAIT_SETL] = (state_r == CPS_WAIT) && waitSettle;
        rdData[`CPS_ST_LOCKED]    = lockSync_r;
        rdData[`CPS_ST_PIN_HIGH]  = powerdownPin;
        rdData[`CPS_ST_PUP_DONE]  = pupDone;
      end
      default:
        rdData = 32'h0000_0000;
    endcase
  end

  // Wishbone answer: ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wbHit;
      wb_dat_o <= wbHit ? rdData : 32'h0000_0000;
    end
  end
endmodule : cps_ctrl
`default_nettype wire

/* File: tb/cps_ctrl_props.sv */
// Bus and serial-link assertions for the control-port host controller
`default_nettype none
module cps_ctrl_props (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        powerdownPin,
  input wire logic        interfaceSelect,
  input wire logic        chipSelectLow,
  input wire logic        controlSerialClock,
  input wire logic        controlSerialIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sclR;
  logic [7:0] gapCnt_r;
  logic [7:0] upCnt_r;
  logic [4:0] riseCnt_r;

  // Cycles since the serial clock last changed, and rises seen in this frame
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclR      <= 1'b1;
      gapCnt_r  <= 8'h00;
      riseCnt_r <= 5'h00;
    end
    else
    begin
      sclR      <= controlSerialClock;
      gapCnt_r  <= (controlSerialClock != sclR) ? 8'h00 : gapCnt_r + 8'(gapCnt_r != 8'hff);
      riseCnt_r <= chipSelectLow ? 5'h00 : riseCnt_r + 5'(controlSerialClock && !sclR);
    end
  end

  // Cycles since reset, saturating
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      upCnt_r <= 8'h00;
    else
      upCnt_r <= upCnt_r + 8'(upCnt_r != 8'hff);
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  property p_ackOne; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOne: assert property (p_ackOne) else $error("ack held too long");
  property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ackNext: assert property (p_ackNext) else $error("ack late");
  property p_datIdle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_datIdle: assert property (p_datIdle) else $error("read data outside ack");
  property p_gap; controlSerialClock != sclR |-> gapCnt_r >= 8'd19; endproperty
  a_gap: assert property (p_gap) else $error("serial clock too fast");
  property p_idle; chipSelectLow |-> controlSerialClock; endproperty
  a_idle: assert property (p_idle) else $error("clock low while idle");
  property p_stable; $rose(controlSerialClock) |-> $stable(controlSerialIn); endproperty
  a_stable: assert property (p_stable) else $error("data moved at rise");
  property p_head;
    $rose(controlSerialClock) && riseCnt_r < 5'd3 |-> controlSerialIn == (riseCnt_r != 5'd0);
  endproperty
  a_head: assert property (p_head) else $error("bad frame header");
  property p_len; $rose(chipSelectLow) |-> riseCnt_r == 5'd16; endproperty
  a_len: assert property (p_len) else $error("frame not 16 clocks");
  property p_start; $fell(chipSelectLow) |-> powerdownPin && !interfaceSelect; endproperty
  a_start: assert property (p_start) else $error("frame in wrong mode");
  property p_pwrUp; $rose(powerdownPin) |-> upCnt_r >= 8'd30; endproperty
  a_pwrUp: assert property (p_pwrUp) else $error("pin released early");

  c_frame: cover property ($rose(chipSelectLow));
  c_pwrUp: cover property ($rose(powerdownPin));
  c_ack: cover property (wb_ack_o && wb_cyc_i);
endmodule : cps_ctrl_props

bind cps_ctrl cps_ctrl_props u_cps_ctrl_props (
  .clock, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .powerdownPin,
  .interfaceSelect, .chipSelectLow, .controlSerialClock, .controlSerialIn);
`default_nettype wire

/* File: tb/cps_dev_model.sv */
// Behavioural codec control port: registers written over the three-wire link
`default_nettype none
module cps_dev_model (
  input  wire logic clock,
  input  wire logic powerdownPin,
  input  wire logic interfaceSelect,
  input  wire logic chipSelectLow,
  input  wire logic controlSerialClock,
  input  wire logic controlSerialIn,
  output var  logic pllLocked
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  regs [0:19];
  logic [15:0] shiftR;
  time         commitT [0:19];
  int          bitCnt = 0;
  int          frames = 0;

  always @(negedge chipSelectLow)
    bitCnt = 0;

  always @(posedge controlSerialClock)
  begin
    if (chipSelectLow === 1'b0 && interfaceSelect === 1'b0)
    begin
      shiftR = {shiftR[14:0], controlSerialIn};
      bitCnt++;
      // Commit only whole frames with the fixed header, in range, while powered
      if (bitCnt == 16 && powerdownPin === 1'b1 && shiftR[15:13] === 3'b011 &&
          shiftR[12:8] < 5'h14)
      begin
        regs[shiftR[12:8]] = shiftR[7:0];
        commitT[shiftR[12:8]] = $time;
        frames++;
      end
    end
  end

  // Lock follows PLL power; no audio clock is needed for it
  always @(posedge clock)
  begin
    if (powerdownPin !== 1'b1)
      foreach (regs[i])
        regs[i] <= (i == 1) ? 8'h80 : 8'h00;
    pllLocked <= (powerdownPin === 1'b1) && (regs[0][6] === 1'b1);
  end
endmodule : cps_dev_model
`default_nettype wire

/* File: tb/cps_ctrl_tb.sv */
// Self-checking bench for the control-port host controller
`default_nettype none
module cps_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SETTLE = 2000;
  logic        clock = 1'b0;
  logic        sys_rst;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic        wbAck;
  logic [7:0]  wbAdr;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic [31:0] rdData;
  logic        pllLocked;
  logic        powerdownPin;
  logic        interfaceSelect;
  logic        chipSelectLow;
  logic        controlSerialClock;
  logic        controlSerialIn;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  always #2.5 clock = ~clock;

  cps_ctrl #(.SETTLE_CYC(SETTLE)) u_cps_ctrl (
    .clock, .sys_rst, .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .pllLockedIn(pllLocked), .powerdownPin, .interfaceSelect,
    .chipSelectLow, .controlSerialClock, .controlSerialIn);
  cps_dev_model u_cps_dev_model (
    .clock, .powerdownPin, .interfaceSelect, .chipSelectLow,
    .controlSerialClock, .controlSerialIn, .pllLocked);

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wbXfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= w;
    wbAdr  <= a;
    wbDatI <= d;
    @(posedge clock);
    while (wbAck !== 1'b1)
      @(posedge clock);
    rdData = wbDatO;
    wbCyc  <= 1'b0;
    wbStb  <= 1'b0;
    @(posedge clock);
  endtask : wbXfer

  // Issue one register write and poll status until idle; rdData ends as status
  task automatic cmd(input logic [4:0] a, input logic [7:0] d);
    wbXfer(1'b1, 8'h04, {19'h0, a, d});
    rdData = 32'h1;
    while (rdData[0] !== 1'b0)
      wbXfer(1'b0, 8'h08, 32'h0);
  endtask : cmd

  task automatic powerOn;
    wbXfer(1'b1, 8'h00, 32'h1);
    wbXfer(1'b1, 8'h08, 32'h2);
    while (powerdownPin !== 1'b1)
      @(posedge clock);
  endtask : powerOn

  function automatic logic [31:0] dev(input int i);
    return 32'(u_cps_dev_model.regs[i]);
  endfunction : dev

  initial
  begin
    sys_rst = 1'b1;
    wbCyc   = 1'b0;
    wbStb   = 1'b0;
    wbWe    = 1'b0;
    wbAdr   = 8'h00;
    wbDatI  = 32'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk("pin low", 32'h0, 32'(powerdownPin));
    chk("cs idle", 32'h1, 32'(chipSelectLow));
    wbXfer(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 32'h0, rdData);
    cmd(5'h01, 8'h5a);
    chk("refused low", 32'h2, rdData & 32'h3);
    chk("no frame", 32'h0, 32'(u_cps_dev_model.frames));
    powerOn();
    chk("default", 32'h80, dev(1));
    cmd(5'h01, 8'ha5);
    chk("reg 01", 32'ha5, dev(1));
    cmd(5'h13, 8'h0f);
    chk("reg 13", 32'h0f, dev(19));
    cmd(5'h14, 8'hff);
    chk("refused 14", 32'h2, rdData & 32'h3);
    chk("frames", 32'h2, 32'(u_cps_dev_model.frames));
    // Path write without lock waits, then powering down aborts it
    wbXfer(1'b1, 8'h08, 32'h2);
    wbXfer(1'b1, 8'h04, 32'h0701);
    wbXfer(1'b0, 8'h08, 32'h0);
    chk("wait lock", 32'h5, rdData & 32'h7);
    wbXfer(1'b1, 8'h00, 32'h0);
    wbXfer(1'b0, 8'h08, 32'h0);
    chk("abort", 32'h2, rdData & 32'h7);
    chk("cleared", 32'h80, dev(1));
    powerOn();
    cmd(5'h00, 8'h41);
    cmd(5'h07, 8'h01);
    cmd(5'h00, 8'h5d);
    chk("settle", 32'h1,
        32'((u_cps_dev_model.commitT[0] - u_cps_dev_model.commitT[7]) >= SETTLE * 5));
    chk("path", 32'h01, dev(7));
    chk("hp on", 32'h5d, dev(0));
    cmd(5'h07, 8'h00);
    chk("hp path held", 32'h2, rdData & 32'h3);
    wbXfer(1'b1, 8'h08, 32'h2);
    cmd(5'h00, 8'h41);
    cmd(5'h07, 8'h00);
    chk("hp path off", 32'h00, dev(7));
    wbXfer(1'b1, 8'h00, 32'h3);
    chk("two-wire pin", 32'h1, 32'(interfaceSelect));
    cmd(5'h02, 8'h11);
    chk("two-wire cmd", 32'h2, rdData & 32'h3);
    summarize();
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      failures++;
      summarize();
    end
  end
endmodule : cps_ctrl_tb
`default_nettype wire
